// ---- hw/press_cycle_release_outputs.sv ----
// Press cyclic-operation release, pending and error outputs with AHB-Lite registers
`include "press_cycle_defines.svh"

// Operation
// - Permit high forces restart-pending low; both may be low.
// - Restart-pending holds until a valid start; permit stays low meanwhile.
// - Intervention-pending is high while waiting for a light-curtain cycle.
// - Sequence-timeout rises when a cycle sequence exceeds the configured limit.
// - Intrusion at a disallowed time raises unauthorized-intrusion; acknowledged per mode.
// - Permit lost on main or cycle input raises return-to-top, blocking restart.
// - Enabled summary-fault follows sequence-timeout or unauthorized-intrusion.
// - Either error forces permit low, and summary-fault high when it is enabled.
// - Sequence-timeout clears only on a complete start sequence.
// - Main permit input low drives the press permit low at once.
// - Start pulse high time between configured minimum and 30 s, else ignored.
// - Cycle low time must reach 100 ms or 350 ms to count.
// - Interlock mode 1 none, 2 always, 3 after downstroke or initial stop.
module press_cycle_release_outputs #(
  parameter int MS_CYCLES = `PCR_MS_CYCLES
) (
  input  wire logic                hclk,           // Bus and logic clock
  input  wire logic                hresetn,        // Asynchronous reset, active low
  input  wire logic                ce,             // Logic-cycle enable
  input  wire logic                hsel,           // Slave select
  input  wire logic [31:0]         haddr,          // Byte address
  input  wire logic [1:0]          htrans,         // Transfer type
  input  wire logic                hwrite,         // Write strobe
  input  wire logic [2:0]          hsize,          // Transfer size
  input  wire logic [31:0]         hwdata,         // Write data
  input  wire logic                hready,         // Bus ready
  output logic      [31:0]         hrdata,         // Read data
  output logic                     hreadyout,      // Slave ready
  output logic                     hresp,          // Always OKAY
  input  wire logic                main_permit_in, // Main permit from press monitor
  input  wire logic                cycle_in,       // Light-curtain cycle input
  input  wire logic                top_in,         // Top dead centre
  input  wire logic                start_in,       // Start pushbutton
  input  wire logic                startup_in,     // Startup contact for muting
  input  wire logic                other_start_in, // Start in another mode
  output logic                     permit,         // Press permit
  output logic                     start_req,      // Restart pending
  output logic                     cycle_req,      // Intervention pending
  output logic                     seq_timeout,    // Sequence timeout
  output logic                     intrusion,      // Unauthorized intrusion
  output logic                     top_needed,     // Return to top needed
  output logic                     err_flag,       // Summary fault
  output logic                     irq             // Interrupt, active high
);
  import press_cycle_pkg::*;
  localparam int PW = $clog2(MS_CYCLES + 1);

  // ********************
  // Input synchronisers
  // ********************
  // Third stage keeps the previous synchronised level for edge detection
  logic [5:0] sy1_r, sy2_r, dl_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sy1_r <= 6'h00;
      sy2_r <= 6'h00;
      dl_r  <= 6'h00;
    end else if (ce) begin
      sy1_r <= {other_start_in, startup_in, start_in, top_in, cycle_in, main_permit_in};
      sy2_r <= sy1_r;
      dl_r  <= sy2_r;
    end
  end
  logic main_s, cyc_s, top_s, st_s, sup_s, oth_s;
  assign {oth_s, sup_s, st_s, top_s, cyc_s, main_s} = sy2_r;
  logic cyc_rise, cyc_fall, st_fall;
  assign cyc_rise = cyc_s & ~dl_r[1];
  assign cyc_fall = ~cyc_s & dl_r[1];
  assign st_fall  = ~st_s & dl_r[3];

  // ********************
  // Registers
  // ********************
  logic [31:0]          ctrl_r;
  logic [15:0]          cyc_lim_r, mute_lim_r;
  logic [`PCR_EV_W-1:0] status_r, mask_r, ev;
  logic                 wr_pend_r;
  logic [7:0]           addr_r;
  ilock_mode_t          mode;
  logic [3:0]           cfg_cnt;
  assign mode    = ctrl_r[`PCR_CTRL_MODE];
  assign cfg_cnt = ctrl_r[`PCR_CTRL_CNT];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ********************
  // Timers
  // ********************
  logic [PW-1:0] pre_r, hi_pre_r, lo_pre_r;
  logic          ms_tick, hi_tick, lo_tick;
  logic [14:0]   hi_ms_r, smin;
  logic [8:0]    lo_ms_r, cmin;
  logic [9:0]    seq_ms_r, mute_ms_r;
  logic [15:0]   seq_s_r, mute_s_r;
  cyc_state_t    state_r;
  assign ms_tick = (pre_r == PW'(MS_CYCLES - 1));
  // Pulse widths are timed from their own edge, so no pulse gains a tick from the free prescaler
  assign hi_tick = (hi_pre_r == PW'(MS_CYCLES - 1));
  assign lo_tick = (lo_pre_r == PW'(MS_CYCLES - 1));
  always_comb begin
    if (ctrl_r[`PCR_CTRL_SMIN] == 2'd0) smin = `PCR_START_MIN0_MS;
    else if (ctrl_r[`PCR_CTRL_SMIN] == 2'd1) smin = `PCR_START_MIN1_MS;
    else smin = `PCR_START_MIN2_MS;
    cmin = ctrl_r[`PCR_CTRL_CMIN] ? `PCR_CYC_MIN1_MS : `PCR_CYC_MIN0_MS;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r     <= '0;
      hi_pre_r  <= '0;
      lo_pre_r  <= '0;
      hi_ms_r   <= 15'h0000;
      lo_ms_r   <= 9'h000;
      seq_ms_r  <= 10'h000;
      seq_s_r   <= 16'h0000;
      mute_ms_r <= 10'h000;
      mute_s_r  <= 16'h0000;
    end else if (ce) begin
      pre_r <= ms_tick ? '0 : pre_r + 1'b1;
      if (!st_s) begin
        hi_pre_r <= '0;
        hi_ms_r  <= 15'h0000;
      end else begin
        hi_pre_r <= hi_tick ? '0 : hi_pre_r + 1'b1;
        if (hi_tick && hi_ms_r <= `PCR_START_MAX_MS) hi_ms_r <= hi_ms_r + 15'h0001;
      end
      if (cyc_s) begin
        lo_pre_r <= '0;
        lo_ms_r  <= 9'h000;
      end else begin
        lo_pre_r <= lo_tick ? '0 : lo_pre_r + 1'b1;
        if (lo_tick && lo_ms_r != 9'h1ff) lo_ms_r <= lo_ms_r + 9'h001;
      end
      if (state_r != ST_CYCLE_WAIT) begin
        seq_ms_r <= 10'h000;
        seq_s_r  <= 16'h0000;
      end else if (ms_tick) begin
        seq_ms_r <= (seq_ms_r == `PCR_MS_PER_S - 10'd1) ? 10'h000 : seq_ms_r + 10'h001;
        if (seq_ms_r == `PCR_MS_PER_S - 10'd1 && seq_s_r != 16'hffff) seq_s_r <= seq_s_r + 16'h0001;
      end
      if (!sup_s || top_s) begin
        mute_ms_r <= 10'h000;
        mute_s_r  <= 16'h0000;
      end else if (ms_tick) begin
        mute_ms_r <= (mute_ms_r == `PCR_MS_PER_S - 10'd1) ? 10'h000 : mute_ms_r + 10'h001;
        if (mute_ms_r == `PCR_MS_PER_S - 10'd1 && mute_s_r != 16'hffff) mute_s_r <= mute_s_r + 16'h0001;
      end
    end
  end
  logic start_ok, cyc_ok, mute_act;
  assign start_ok = st_fall && hi_ms_r >= smin && hi_ms_r <= `PCR_START_MAX_MS;
  assign cyc_ok   = cyc_rise && lo_ms_r >= cmin;
  // Startup muting bypasses the cycle input until top is reached or the limit runs out
  assign mute_act = sup_s && !top_s && mute_lim_r != 16'h0000 && mute_s_r < mute_lim_r;

  // ********************
  // Sequence control
  // ********************
  logic [3:0] cnt_r;
  logic       to_r, intr_r, topn_r, permit_r;
  logic       drop, to_set, intr_set, errs, start_acc;
  assign drop     = state_r == ST_RUN && (!main_s || (!cyc_s && !mute_act));
  assign to_set   = state_r == ST_CYCLE_WAIT && cyc_lim_r != 16'h0000 && seq_s_r >= cyc_lim_r;
  assign intr_set = cyc_fall && mute_act && mode == 2'd2;
  assign errs     = to_r || intr_r;
  // A start is complete only when the press may really leave the interlock
  assign start_acc = start_ok && main_s && !topn_r && state_r == ST_START_WAIT;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_START_WAIT;
      cnt_r   <= 4'h0;
    end else if (ce) begin
      // Errors override every state and force a complete start
      if (to_set || intr_set) begin
        state_r <= ST_START_WAIT;
      end else begin
        case (state_r)
          ST_START_WAIT: begin
            if (start_acc) begin
              state_r <= ST_CYCLE_WAIT;
              cnt_r   <= 4'h0;
            end
          end
          ST_CYCLE_WAIT: begin
            if (cyc_ok && !topn_r) begin
              if (cnt_r + 4'h1 >= cfg_cnt) state_r <= ST_RUN;
              else cnt_r <= cnt_r + 4'h1;
            end
          end
          ST_RUN: begin
            if (drop) begin
              if (mode == 2'd2 || (mode == 2'd3 && !top_s)) state_r <= ST_START_WAIT;
              else state_r <= ST_CYCLE_WAIT;
              cnt_r <= 4'h0;
            end
          end
          default: state_r <= ST_START_WAIT;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      to_r   <= 1'b0;
      intr_r <= 1'b0;
      topn_r <= 1'b0;
    end else if (ce) begin
      if (to_set) to_r <= 1'b1;
      else if (start_acc) to_r <= 1'b0;
      if (intr_set) intr_r <= 1'b1;
      else if (mode == 2'd2 ? start_acc : cyc_rise) intr_r <= 1'b0;
      if (drop) topn_r <= 1'b1;
      else if (top_s && !oth_s) topn_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) permit_r <= 1'b0;
    else if (ce) permit_r <= state_r == ST_RUN && main_s && (cyc_s || mute_act) && !topn_r;
  end
  // Main permit gates the output directly, so a stop costs no extra cycle
  assign permit      = permit_r && state_r == ST_RUN && !errs && main_s;
  assign start_req   = state_r == ST_START_WAIT;
  assign cycle_req   = state_r == ST_CYCLE_WAIT;
  assign seq_timeout = to_r;
  assign intrusion   = intr_r;
  assign top_needed  = topn_r;
  assign err_flag    = ctrl_r[`PCR_CTRL_ERREN] && errs;

  // ********************
  // Bus slave and interrupt
  // ********************
  assign ev  = {start_acc, drop, intr_set, to_set};
  assign irq = |(status_r & mask_r);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r  <= 1'b0;
      addr_r     <= 8'h00;
      hrdata     <= 32'h0000_0000;
      ctrl_r     <= `PCR_CTRL_RST;
      cyc_lim_r  <= `PCR_CYC_LIM_RST;
      mute_lim_r <= `PCR_MUTE_LIM_RST;
      mask_r     <= '0;
      status_r   <= '0;
    end else if (ce) begin
      wr_pend_r <= hready && hsel && htrans[1] && hwrite;
      addr_r    <= haddr[7:0];
      if (hready && hsel && htrans[1] && !hwrite) begin
        if (haddr[7:0] == `PCR_OFF_CTRL) hrdata <= ctrl_r;
        else if (haddr[7:0] == `PCR_OFF_CYC_LIM) hrdata <= {16'h0000, cyc_lim_r};
        else if (haddr[7:0] == `PCR_OFF_MUTE_LIM) hrdata <= {16'h0000, mute_lim_r};
        else if (haddr[7:0] == `PCR_OFF_STATUS) hrdata <= {28'h0000000, status_r};
        else if (haddr[7:0] == `PCR_OFF_MASK) hrdata <= {28'h0000000, mask_r};
        else if (haddr[7:0] == `PCR_OFF_STATE)
          hrdata <= {24'h000000, irq, err_flag, top_needed, intrusion, seq_timeout, cycle_req, start_req, permit};
        else hrdata <= 32'h0000_0000;
      end
      if (wr_pend_r && addr_r == `PCR_OFF_CTRL) ctrl_r <= {20'h00000, hwdata[11:0]};
      if (wr_pend_r && addr_r == `PCR_OFF_CYC_LIM) cyc_lim_r <= hwdata[15:0];
      if (wr_pend_r && addr_r == `PCR_OFF_MUTE_LIM) mute_lim_r <= hwdata[15:0];
      if (wr_pend_r && addr_r == `PCR_OFF_MASK) mask_r <= hwdata[`PCR_EV_W-1:0];
      // Set wins over a write-one clear in the same cycle
      if (wr_pend_r && addr_r == `PCR_OFF_STATUS) status_r <= (status_r & ~hwdata[`PCR_EV_W-1:0]) | ev;
      else status_r <= status_r | ev;
    end
  end

  // ********************
  // Assertions
  // ********************
  // All properties run on the bus clock and rest while reset is active
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_permit_excl: assert property (permit |-> !start_req && !cycle_req) else $error("permit with pending");
  a_start_hold: assert property (start_req && !(ce && start_ok) && ce |=> start_req) else $error("start lost");
  a_cycle_wait: assert property (ce && cycle_req && cyc_ok && !topn_r && !to_set && cfg_cnt <= 4'h1 |=> permit_r == 1'b0 && !cycle_req)
    else $error("cycle wait stuck");
  a_timeout_set: assert property (ce && to_set |=> seq_timeout && start_req) else $error("timeout missed");
  a_intr_set: assert property (ce && intr_set |=> intrusion && !permit) else $error("intrusion missed");
  a_top_flag: assert property (ce && drop |=> top_needed ##0 !permit) else $error("top flag missed");
  a_err_flag: assert property (ctrl_r[5] && (seq_timeout || intrusion) |-> err_flag) else $error("fault flag");
  a_err_force: assert property (seq_timeout || intrusion |-> !permit) else $error("permit in error");
  a_to_sticky: assert property (seq_timeout && !(ce && start_ok) |=> seq_timeout) else $error("timeout cleared");
  a_main_low: assert property (ce && !main_s |=> !permit) else $error("permit on main low");
  a_start_long: assert property (ce && start_req && st_fall && hi_ms_r > `PCR_START_MAX_MS |=> start_req)
    else $error("long start");
  a_cyc_short: assert property (ce && cycle_req && cyc_rise && lo_ms_r < cmin && !to_set |=> cycle_req)
    else $error("short cycle");
  a_mode_two: assert property (ce && drop && mode == 2'd2 |=> start_req) else $error("interlock skipped");
  a_mode_one: assert property (ce && drop && mode == 2'd1 |=> cycle_req) else $error("needless interlock");
  a_mode_three: assert property (ce && drop && mode == 2'd3 && !top_s |=> start_req) else $error("downstroke stop");
  a_top_hold: assert property (ce && start_req && top_needed |=> start_req) else $error("start before top");
  a_ce_hold: assert property (!ce |=> $stable(state_r) && $stable(status_r)) else $error("state moved");
  c_run: cover property (ce && cycle_req ##1 permit);
  c_top_clear: cover property (top_needed ##1 !top_needed);
  c_timeout: cover property (seq_timeout ##[1:100] !seq_timeout);
  c_intr: cover property (intr_set);
endmodule

// ---- hw/press_cycle_defines.svh ----
// Constants of the press cyclic-operation release block
`ifndef PRESS_CYCLE_DEFINES_SVH
`define PRESS_CYCLE_DEFINES_SVH
`define PCR_CLK_NS        10
`define PCR_MS_NS         1000000
`define PCR_MS_CYCLES     (`PCR_MS_NS / `PCR_CLK_NS)
`define PCR_MS_PER_S      10'd1000
`define PCR_START_MAX_MS  15'd30000
`define PCR_START_MIN0_MS 15'd1
`define PCR_START_MIN1_MS 15'd100
`define PCR_START_MIN2_MS 15'd350
`define PCR_CYC_MIN0_MS   9'd100
`define PCR_CYC_MIN1_MS   9'd350
`define PCR_OFF_CTRL      8'h00
`define PCR_OFF_CYC_LIM   8'h04
`define PCR_OFF_MUTE_LIM  8'h08
`define PCR_OFF_STATUS    8'h0c
`define PCR_OFF_MASK      8'h10
`define PCR_OFF_STATE     8'h14
`define PCR_CTRL_MODE     1:0
`define PCR_CTRL_SMIN     3:2
`define PCR_CTRL_CMIN     4
`define PCR_CTRL_ERREN    5
`define PCR_CTRL_CNT      11:8
`define PCR_CTRL_RST      32'h0000_0122
`define PCR_CYC_LIM_RST   16'h0000
`define PCR_MUTE_LIM_RST  16'h0000
`define PCR_EV_W          4
`endif

// ---- hw/press_cycle_pkg.sv ----
// Types of the press cyclic-operation release block
package press_cycle_pkg;
  typedef enum logic [1:0] {ST_START_WAIT, ST_CYCLE_WAIT, ST_RUN} cyc_state_t;
  typedef logic [1:0] ilock_mode_t;
endpackage

// ---- verification/press_field.sv ----
// Behavioural far side: press contact monitor, light curtain and start button
module press_field (
  input  wire logic hclk,           // Logic clock
  output logic      main_permit_in, // Main permit from press monitor
  output logic      cycle_in,       // Light-curtain cycle input
  output logic      top_in,         // Top dead centre
  output logic      start_in,       // Start pushbutton
  output logic      startup_in,     // Startup contact
  output logic      other_start_in  // Start in another mode
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Idle: permit on, curtain clear, press below top
  // ****************************************
  initial begin
    main_permit_in = 1'b1;
    cycle_in       = 1'b1;
    top_in         = 1'b0;
    start_in       = 1'b0;
    startup_in     = 1'b0;
    other_start_in = 1'b0;
  end
  task automatic press_start(input int n);
    @(posedge hclk);
    start_in <= 1'b1;
    repeat (n) @(posedge hclk);
    start_in <= 1'b0;
  endtask
  task automatic intervene(input int n);
    @(posedge hclk);
    cycle_in <= 1'b0;
    repeat (n) @(posedge hclk);
    cycle_in <= 1'b1;
  endtask
  task automatic drive(input logic m, input logic t);
    @(posedge hclk);
    main_permit_in <= m;
    top_in         <= t;
  endtask
  task automatic set_aux(input logic su, input logic os);
    @(posedge hclk);
    startup_in     <= su;
    other_start_in <= os;
  endtask
endmodule

// ---- verification/press_cycle_release_outputs_bench.sv ----
// Self-checking bench of the press cyclic-operation release block
module press_cycle_release_outputs_bench;
  import press_cycle_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals, clock and instances
  // ****************************************
  logic        hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0, rd_phase = 0;
  logic [31:0] haddr = '0, hwdata = '0, rng = 32'h75d2;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, permit, start_req, cycle_req, seq_timeout, intrusion, top_needed, err_flag, irq;
  logic        main_permit_in, cycle_in, top_in, start_in, startup_in, other_start_in;
  logic [63:0] exp_q[$];
  logic [63:0] e_w;
  logic [7:0]  pins;
  string       name_q[$];
  int          num_errors = 0;
  int          cmp_count = 0;
  always #5 hclk = ~hclk;
  press_cycle_release_outputs #(.MS_CYCLES(10)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .main_permit_in(main_permit_in), .cycle_in(cycle_in),
    .top_in(top_in), .start_in(start_in), .startup_in(startup_in), .other_start_in(other_start_in),
    .permit(permit), .start_req(start_req), .cycle_req(cycle_req), .seq_timeout(seq_timeout),
    .intrusion(intrusion), .top_needed(top_needed), .err_flag(err_flag), .irq(irq));
  press_field pf (
    .hclk(hclk), .main_permit_in(main_permit_in), .cycle_in(cycle_in), .top_in(top_in),
    .start_in(start_in), .startup_in(startup_in), .other_start_in(other_start_in));
  // ****************************************
  // Read data monitor, closing report, bus tasks
  // ****************************************
  always @(posedge hclk) begin
    if (rd_phase && hreadyout === 1'b1) begin
      e_w = exp_q.pop_front();
      cmp_count++;
      if ((hrdata & e_w[63:32]) !== e_w[31:0]) begin
        num_errors++;
        $display("MISMATCH %s expected %h seen %h", name_q[0], e_w[31:0], hrdata & e_w[63:32]);
      end
      if (name_q[0] == "state") begin
        pins = {irq, err_flag, top_needed, intrusion, seq_timeout, cycle_req, start_req, permit};
        cmp_count++;
        if ((pins & e_w[39:32]) !== e_w[7:0]) begin
          num_errors++;
          $display("MISMATCH pins expected %h seen %h", e_w[7:0], pins & e_w[39:32]);
        end
      end
      cmp_count++;
      if (hresp !== 1'b0) begin
        num_errors++;
        $display("MISMATCH hresp expected 0 seen %b", hresp);
      end
      void'(name_q.pop_front());
    end
  end
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input string nm);
    int n;
    n = 0;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 200);
    htrans   <= 2'h0;
    hsel     <= 1'b0;
    hwdata   <= d;
    rd_phase <= !w;
    if (!w) begin
      exp_q.push_back({m, d & m});
      name_q.push_back(nm);
    end
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 200);
    rd_phase <= 1'b0;
    if (n >= 200) begin num_errors++; wrap_up(); end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m, input string nm);
    bus(1'b0, a, v, m, nm);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0, "");
  endtask
  task automatic settle();
    repeat (12) @(posedge hclk);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h00, 32'h122, '1, "ctrl");
    rd(8'h04, 32'h0, 32'hffff, "cyc_lim");
    rd(8'h40, 32'h0, '1, "unmapped");
    rd(8'h14, 32'h02, 32'hff, "state");
    for (int m = 1; m < 4; m++) begin
      wr(8'h00, 32'h120 | m);
      rd(8'h00, 32'h120 | m, '1, "ctrl");
    end
    wr(8'h00, 32'h122);
    rng = lfsr(rng);
    pf.press_start(3 + rng[0]);
    settle();
    rd(8'h14, 32'h02, 32'hff, "state");
    ce <= 1'b0;
    pf.press_start(30);
    settle();
    ce <= 1'b1;
    rd(8'h14, 32'h02, 32'hff, "state");
    rng = lfsr(rng);
    pf.press_start(12 + rng[4:1]);
    settle();
    rd(8'h14, 32'h04, 32'hff, "state");
    rd(8'h0c, 32'h8, 32'h8, "status");
    wr(8'h0c, 32'hf);
    rng = lfsr(rng);
    pf.intervene(300 + rng[7:0]);
    settle();
    rd(8'h14, 32'h04, 32'hff, "state");
    pf.intervene(1100);
    settle();
    rd(8'h14, 32'h01, 32'hff, "state");
    wr(8'h10, 32'h4);
    pf.drive(1'b0, 1'b0);
    settle();
    rd(8'h14, 32'ha2, 32'hff, "state");
    rd(8'h0c, 32'h4, 32'hf, "status");
    wr(8'h0c, 32'h4);
    pf.drive(1'b1, 1'b0);
    pf.press_start(20);
    settle();
    rd(8'h14, 32'h22, 32'hff, "state");
    pf.drive(1'b1, 1'b1);
    settle();
    rd(8'h14, 32'h02, 32'hff, "state");
    pf.drive(1'b1, 1'b0);
    wr(8'h04, 32'h1);
    pf.press_start(20);
    repeat (10100) @(posedge hclk);
    rd(8'h14, 32'h48, 32'h49, "state");
    wr(8'h00, 32'h102);
    rd(8'h14, 32'h08, 32'h49, "state");
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h122);
    pf.press_start(20);
    settle();
    rd(8'h14, 32'h04, 32'h0c, "state");
    wr(8'h08, 32'h1);
    pf.set_aux(1'b1, 1'b0);
    pf.intervene(50);
    settle();
    rd(8'h14, 32'h52, 32'hff, "state");
    pf.set_aux(1'b0, 1'b0);
    pf.press_start(20);
    settle();
    rd(8'h14, 32'h04, 32'hff, "state");
    wr(8'h00, 32'h121);
    pf.intervene(1100);
    settle();
    rd(8'h14, 32'h01, 32'hff, "state");
    pf.drive(1'b0, 1'b0);
    settle();
    rd(8'h14, 32'ha4, 32'hff, "state");
    pf.set_aux(1'b0, 1'b1);
    pf.drive(1'b1, 1'b1);
    settle();
    rd(8'h14, 32'ha4, 32'hff, "state");
    pf.set_aux(1'b0, 1'b0);
    settle();
    rd(8'h14, 32'h84, 32'hff, "state");
    wr(8'h0c, 32'hf);
    pf.drive(1'b1, 1'b0);
    wr(8'h00, 32'h123);
    pf.intervene(1100);
    settle();
    pf.drive(1'b0, 1'b0);
    settle();
    rd(8'h14, 32'ha2, 32'hff, "state");
    wrap_up();
  end
endmodule
